// [bench/phy_port_status_and_id_pages_tb.sv]
`timescale 1ns/1ps
module phy_port_status_and_id_pages_tb
   import phyps_pkg::*;
;
   localparam logic [2:0] CAP = SPD_S800;
   localparam logic [7:0] COMPL = 8'h5A;
   // arbitrary identity values
   localparam logic [23:0] MAKER = 24'h3C4D5E;
   localparam logic [23:0] PART = 24'h102030;
   localparam logic [6:0] EV_START = 7'h40;
   localparam logic [6:0] EV_NEG = 7'h20;
   localparam logic [6:0] EV_SYNC = 7'h10;
   localparam logic [6:0] EV_LOOP = 7'h08;
   localparam logic [6:0] EV_BUSRST = 7'h04;
   localparam logic [6:0] EV_REMOTE = 7'h02;
   localparam logic [6:0] EV_BAD = 7'h01;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic plug = 1'b0;
   logic beta = 1'b0;
   logic stby = 1'b0;
   logic [6:0] ev = 7'h00;
   phyps_phy_in_t phy_in;
   phyps_phy_out_t phy_out;
   logic [7:0] idb [8] = '{COMPL, 8'h00, MAKER[23:16], MAKER[15:8], MAKER[7:0], PART[23:16], PART[15:8], PART[7:0]};
   int miscompares = 0;
   int cmp_count = 0;
   int cyc = 0;

   always #25 aclk = ~aclk;

   phyps_regs #(.PORT_MAX_SPEED(CAP), .DEBOUNCE_CYCLES(8), .COMPLIANCE(COMPL), .MAKER_IDENT(MAKER),
      .PART_IDENT(PART)) u_phyps_regs (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .phy_in(phy_in), .phy_out(phy_out));

   phyps_peer u_phyps_peer (.aclk(aclk), .aresetn(aresetn), .plug(plug), .beta(beta), .stby(stby),
      .ev(ev), .phy_out(phy_out), .phy_in(phy_in));

   function automatic logic [7:0] ba(input logic [3:0] i);
      return {2'b00, i, 2'b00};
   endfunction : ba

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // address and data go out together; each is dropped only once taken
   task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = RESP_OKAY);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      chk(rdata, ed);
      chk({30'h0, rresp}, {30'h0, er});
   endtask : axr

   // ev held n edges gives n one-cycle events at the port core
   task automatic pulse(input logic [6:0] e, input int n);
      @(posedge aclk);
      ev <= e;
      repeat (n) @(posedge aclk);
      ev <= 7'h00;
      repeat (3) @(posedge aclk);
   endtask : pulse

   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         miscompares++;
         end_of_test;
      end
   end

   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      axr(ba(PS_SPEED_IDX), {24'h0, 1'b0, CAP, 1'b1, CAP});
      for (int c = 0; c < 8; c++) begin
         // never above S800, the port capability on this bench
         axw(ba(PS_SPEED_IDX), 8'(c), RESP_OKAY);
         axr(ba(PS_SPEED_IDX), {24'h0, 1'b0, CAP, 1'b1, ((3'(c) > CAP) ? CAP : 3'(c))});
      end
      axw(ba(PS_SPEED_IDX), 8'h01, RESP_OKAY);
      pulse(EV_START, 1);
      chk({29'h0, phy_out.conn_speed}, 32'h1);
      axw(ba(PS_SPEED_IDX), 8'h02, RESP_OKAY);
      repeat (3) @(posedge aclk);
      chk({29'h0, phy_out.conn_speed}, 32'h1);
      plug <= 1'b1;
      axr(ba(PS_CTRL_IDX), 32'h0);
      repeat (20) @(posedge aclk);
      axr(ba(PS_CTRL_IDX), 32'h70);
      beta <= 1'b1;
      repeat (4) @(posedge aclk);
      axr(ba(PS_LINK_IDX), 32'h2);
      axr(ba(PS_CTRL_IDX), 32'h30);
      pulse(EV_SYNC, 1);
      axw(ba(PS_LINK_IDX), 8'h00, RESP_OKAY);
      axr(ba(PS_LINK_IDX), 32'h3);
      axw(ba(PS_LINK_IDX), 8'h01, RESP_OKAY);
      axr(ba(PS_LINK_IDX), 32'h2);
      pulse(EV_NEG, 1);
      axr(ba(PS_LINK_IDX), 32'h3);
      pulse(EV_BAD, 3);
      axr(ba(PS_ERR_IDX), 32'h3);
      axr(ba(PS_ERR_IDX), 32'h0);
      pulse(EV_BAD, 300);
      axr(ba(PS_ERR_IDX), 32'hFF);
      pulse(EV_BAD, 5);
      pulse(EV_REMOTE, 1);
      chk({24'h0, phy_out.remote_err_data}, 32'h5);
      axr(ba(PS_ERR_IDX), 32'h0);
      // codewords span the clearing read: the one on the read's edge is dropped, two follow
      ev <= EV_BAD;
      axr(ba(PS_ERR_IDX), 32'h0);
      ev <= 7'h00;
      axr(ba(PS_ERR_IDX), 32'h2);
      pulse(EV_LOOP, 1);
      axr(ba(PS_CTRL_IDX), 32'h31);
      pulse(EV_BUSRST, 1);
      axr(ba(PS_CTRL_IDX), 32'h30);
      pulse(EV_LOOP, 1);
      stby <= 1'b1;
      repeat (3) @(posedge aclk);
      axr(ba(PS_CTRL_IDX), 32'h33);
      stby <= 1'b0;
      axw(ba(PS_CTRL_IDX), 8'h04, RESP_OKAY);
      axr(ba(PS_CTRL_IDX), 32'h35);
      axw(ba(PS_CTRL_IDX), 8'h0C, RESP_OKAY);
      repeat (4) @(posedge aclk);
      axr(ba(PS_CTRL_IDX), 32'h0C);
      // unreliable still set from the failed negotiation; beta gone with the connection
      axr(ba(PS_LINK_IDX), 32'h1);
      chk({30'h0, phy_out.tone_enable, phy_out.ac_maint}, 32'h0);
      pulse(EV_START, 1);
      chk({29'h0, phy_out.conn_speed}, 32'h1);
      axw(ba(PS_CTRL_IDX), 8'h00, RESP_OKAY);
      repeat (20) @(posedge aclk);
      axr(ba(PS_CTRL_IDX), 32'h30);
      axw(ba(PAGE_SEL_IDX), 8'h01, RESP_OKAY);
      for (int i = 8; i < 16; i++) begin
         axr(ba(4'(i)), {24'h0, idb[i-8]});
      end
      axw(ba(PAGE_SEL_IDX), 8'h00, RESP_OKAY);
      axr(ba(PS_SPEED_IDX), {24'h0, 1'b0, CAP, 1'b1, 3'h2});
      axr(8'h40, 32'h0, RESP_SLVERR);
      axw(8'h80, 8'h01, RESP_SLVERR);
      end_of_test;
   end
endmodule : phy_port_status_and_id_pages_tb

// [bench/phyps_peer.sv]
`timescale 1ns/1ps
module phyps_peer
   import phyps_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // scenario control
   input wire logic plug,
   input wire logic beta,
   input wire logic stby,
   input wire logic [6:0] ev,
   // port core side
   input wire phyps_phy_out_t phy_out,
   output phyps_phy_in_t phy_in
);
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phy_in <= '0;
      end else begin
         phy_in.cable_connect <= plug;
         // a hard-disabled port sends no tones, so the peer never sees a valid signal back
         phy_in.rx_signal <= plug & phy_out.tone_enable;
         phy_in.beta_active <= plug & beta;
         phy_in.standby_state <= stby;
         phy_in.beta_conn_start <= ev[6];
         phy_in.speed_neg_fail <= ev[5];
         phy_in.sync_fail <= ev[4];
         phy_in.loop_disable_enter <= ev[3];
         phy_in.bus_reset <= ev[2];
         phy_in.remote_err_rd <= ev[1];
         phy_in.invalid_cw <= ev[0];
      end
   end
endmodule : phyps_peer

// [verilog/phyps_pkg.sv]
package phyps_pkg;
   // register indices; byte address is four times the index
   localparam logic [3:0] PAGE_SEL_IDX = 4'h7;
   localparam logic [3:0] PAGED_BASE_IDX = 4'h8;
   localparam logic [3:0] PS_SPEED_IDX = 4'h8;
   localparam logic [3:0] PS_LINK_IDX = 4'h9;
   localparam logic [3:0] PS_ERR_IDX = 4'hA;
   localparam logic [3:0] PS_CTRL_IDX = 4'hB;
   localparam logic [3:0] ID_COMPL_IDX = 4'h8;
   localparam logic [3:0] ID_RSVD_IDX = 4'h9;
   localparam logic [3:0] ID_MAKER0_IDX = 4'hA;
   localparam logic [3:0] ID_MAKER1_IDX = 4'hB;
   localparam logic [3:0] ID_MAKER2_IDX = 4'hC;
   localparam logic [3:0] ID_PART0_IDX = 4'hD;
   localparam logic [3:0] ID_PART1_IDX = 4'hE;
   localparam logic [3:0] ID_PART2_IDX = 4'hF;
   // pages
   localparam logic [2:0] PAGE_STATUS = 3'h0;
   localparam logic [2:0] PAGE_IDENT = 3'h1;
   localparam logic [2:0] PAGE_RST = 3'h0;
   // speed codes
   localparam logic [2:0] SPD_S100 = 3'h0;
   localparam logic [2:0] SPD_S200 = 3'h1;
   localparam logic [2:0] SPD_S400 = 3'h2;
   localparam logic [2:0] SPD_S800 = 3'h3;
   localparam logic [2:0] SPD_S1600 = 3'h4;
   localparam logic [2:0] SPD_RSVD = 3'h7;
   // field positions
   localparam int SPD_LIMIT_LSB = 0;
   localparam int PLUG_BIT = 3;
   localparam int SPD_CAP_LSB = 4;
   localparam int UNREL_BIT = 0;
   localparam int BETA_BIT = 1;
   localparam int LOOP_BIT = 0;
   localparam int STBY_BIT = 1;
   localparam int DEEP_BIT = 2;
   localparam int DIS_BIT = 3;
   localparam int CON_BIT = 4;
   localparam int RXV_BIT = 5;
   localparam int LEGACY_BIT = 6;
   // counter and timing
   localparam logic [7:0] ERR_MAX = 8'hFF;
   localparam int DEBOUNCE_MS = 341;
   localparam int CLK_HZ = 20_000_000;
   localparam int DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
   localparam int DEB_W = 23;
   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic beta_conn_start;
      logic speed_neg_fail;
      logic sync_fail;
      logic beta_active;
      logic cable_connect;
      logic rx_signal;
      logic invalid_cw;
      logic loop_disable_enter;
      logic bus_reset;
      logic standby_state;
      logic remote_err_rd;
   } phyps_phy_in_t;

   typedef struct packed {
      logic connected;
      logic receive_valid;
      logic beta_mode;
      logic legacy_active;
      logic [2:0] conn_speed;
      logic port_disable;
      logic tone_enable;
      logic ac_maint;
      logic [7:0] remote_err_data;
   } phyps_phy_out_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_got;
      logic aw_bad;
      logic [3:0] aw_idx;
      logic w_got;
      logic [7:0] w_data;
      logic w_lane0;
      logic [2:0] page;
      logic [2:0] speed_limit;
      logic unreliable;
      logic [7:0] err_cnt;
      logic loop_blocked;
      logic deep_disable;
      logic [DEB_W-1:0] deb_cnt;
      phyps_phy_out_t po;
   } phyps_state_t;
endpackage : phyps_pkg

// [verilog/phyps_regs.sv]
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
// Function
// - speed limit is 3 bits; 000..100 give S100..S1600, 111 reserved, 101/110 undefined
// - writing a speed above port capability stores the capability instead
// - speed limit is sampled only when a new beta connection starts
// - power reset loads the speed limit with the port capability
// - local plug flag is read-only and always reads one
// - read-only capability field reports the maximum speed, same coding
// - link-unreliable flag sets on failed speed negotiation or sync failure
// - writing one clears link-unreliable; writing zero leaves it
// - beta indicator is one in beta mode, zero in legacy or disconnected
// - legacy active when connected, receive valid and not beta
// - 8-bit invalid codeword counter increments and saturates at 255
// - any read of the counter, local or remote, clears it
// - loop-blocked flag sets on entering loop-disable state
// - loop-blocked flag clears on bus reset and on disconnection
// - standby flag reads one exactly while port is in standby
// - deep disable acts only while port disable is set
// - deep plus port disable stops toning and forces connected, receive valid low
// - page select value one in base register 7 shows the ident page
// - ident page: compliance, reserved, three maker bytes, three part bytes
// - connected sets after 341 ms stable; hardware reset clears, bus reset not
// - port disable is read/write, hardware reset clears; blocks active connection; alone it only keeps a beta start from taking the speed limit
module phyps_regs
   import phyps_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter logic [2:0] PORT_MAX_SPEED = SPD_S1600,
   parameter int DEBOUNCE_CYCLES = DEBOUNCE_CYC,
   parameter logic [7:0] COMPLIANCE = 8'h02,
   // arbitrary neutral identity values
   parameter logic [23:0] MAKER_IDENT = 24'h123456,
   parameter logic [23:0] PART_IDENT = 24'hABCDEF
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // port core
   input wire phyps_phy_in_t phy_in,
   output phyps_phy_out_t phy_out
);
   localparam logic [DEB_W-1:0] DEB_TARGET = DEB_W'(DEBOUNCE_CYCLES - 1);

   initial begin
      if (ADDR_W < 6 || ADDR_W > 32) $error("ADDR_W out of range");
      if (PORT_MAX_SPEED > SPD_S1600) $error("PORT_MAX_SPEED above S1600");
      if (DEBOUNCE_CYCLES < 1 || DEBOUNCE_CYCLES >= (1 << DEB_W)) $error("DEBOUNCE_CYCLES out of range");
   end

   // {bad, index}: anything above index 15 is unmapped
   function automatic logic [4:0] addr_dec(input logic [ADDR_W-1:0] a);
      addr_dec = {(a >> 6) != '0, a[5:2]};
   endfunction : addr_dec

   // codes above capability, including undefined and reserved ones, fall back to capability
   function automatic logic [2:0] clamp_speed(input logic [2:0] v);
      clamp_speed = (v > PORT_MAX_SPEED) ? PORT_MAX_SPEED : v;
   endfunction : clamp_speed

   phyps_state_t s_reg;
   phyps_state_t s_next;
   logic wr_do;
   logic rd_do;
   logic [4:0] ar_dec;
   logic [4:0] aw_dec;
   logic err_clear;
   logic hard_off;
   logic [31:0] rd_val;

   always_comb begin
      s_next = s_reg;
      aw_dec = addr_dec(s_axi_awaddr);
      ar_dec = addr_dec(s_axi_araddr);
      wr_do = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
      rd_do = s_axi_arvalid && s_reg.arready;
      hard_off = s_reg.po.port_disable && s_reg.deep_disable;
      err_clear = phy_in.remote_err_rd;
      rd_val = 32'h0;

      // write address and data are taken independently
      if (s_axi_awvalid && s_reg.awready) begin
         s_next.aw_got = 1'b1;
         s_next.aw_bad = aw_dec[4];
         s_next.aw_idx = aw_dec[3:0];
      end
      if (s_axi_wvalid && s_reg.wready) begin
         s_next.w_got = 1'b1;
         s_next.w_data = s_axi_wdata[7:0];
         s_next.w_lane0 = s_axi_wstrb[0];
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end

      // read mux; unlisted pages and indices read zero
      if (ar_dec[3:0] == PAGE_SEL_IDX) begin
         rd_val[2:0] = s_reg.page;
      end else if (ar_dec[3:0] >= PAGED_BASE_IDX && s_reg.page == PAGE_STATUS) begin
         unique case (ar_dec[3:0])
            PS_SPEED_IDX: begin
               rd_val[SPD_LIMIT_LSB +: 3] = s_reg.speed_limit;
               rd_val[PLUG_BIT] = 1'b1;
               rd_val[SPD_CAP_LSB +: 3] = PORT_MAX_SPEED;
            end
            PS_LINK_IDX: begin
               rd_val[UNREL_BIT] = s_reg.unreliable;
               rd_val[BETA_BIT] = s_reg.po.beta_mode;
            end
            PS_ERR_IDX: begin
               rd_val[7:0] = s_reg.err_cnt;
               if (rd_do && !ar_dec[4]) err_clear = 1'b1;
            end
            PS_CTRL_IDX: begin
               rd_val[LOOP_BIT] = s_reg.loop_blocked;
               rd_val[STBY_BIT] = phy_in.standby_state;
               rd_val[DEEP_BIT] = s_reg.deep_disable;
               rd_val[DIS_BIT] = s_reg.po.port_disable;
               rd_val[CON_BIT] = s_reg.po.connected;
               rd_val[RXV_BIT] = s_reg.po.receive_valid;
               rd_val[LEGACY_BIT] = s_reg.po.legacy_active;
            end
            default: rd_val = 32'h0;
         endcase
      end else if (ar_dec[3:0] >= PAGED_BASE_IDX && s_reg.page == PAGE_IDENT) begin
         unique case (ar_dec[3:0])
            ID_COMPL_IDX: rd_val[7:0] = COMPLIANCE;
            ID_RSVD_IDX: rd_val[7:0] = 8'h00;
            ID_MAKER0_IDX: rd_val[7:0] = MAKER_IDENT[23:16];
            ID_MAKER1_IDX: rd_val[7:0] = MAKER_IDENT[15:8];
            ID_MAKER2_IDX: rd_val[7:0] = MAKER_IDENT[7:0];
            ID_PART0_IDX: rd_val[7:0] = PART_IDENT[23:16];
            ID_PART1_IDX: rd_val[7:0] = PART_IDENT[15:8];
            ID_PART2_IDX: rd_val[7:0] = PART_IDENT[7:0];
            default: rd_val = 32'h0;
         endcase
      end
      if (rd_do) begin
         s_next.rvalid = 1'b1;
         s_next.rdata = ar_dec[4] ? 32'h0 : rd_val;
         s_next.rresp = ar_dec[4] ? RESP_SLVERR : RESP_OKAY;
      end else if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end

      // failure events win over a simultaneous write-one-to-clear
      if (wr_do && !s_reg.aw_bad && s_reg.w_lane0 && s_reg.page == PAGE_STATUS
          && s_reg.aw_idx == PS_LINK_IDX && s_reg.w_data[UNREL_BIT]) begin
         s_next.unreliable = 1'b0;
      end
      if (phy_in.speed_neg_fail || phy_in.sync_fail) s_next.unreliable = 1'b1;

      // register writes commit once both halves are in
      if (wr_do) begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = s_reg.aw_bad ? RESP_SLVERR : RESP_OKAY;
         if (!s_reg.aw_bad && s_reg.w_lane0) begin
            if (s_reg.aw_idx == PAGE_SEL_IDX) begin
               s_next.page = s_reg.w_data[2:0];
            end else if (s_reg.page == PAGE_STATUS && s_reg.aw_idx == PS_SPEED_IDX) begin
               s_next.speed_limit = clamp_speed(s_reg.w_data[SPD_LIMIT_LSB +: 3]);
            end else if (s_reg.page == PAGE_STATUS && s_reg.aw_idx == PS_CTRL_IDX) begin
               s_next.deep_disable = s_reg.w_data[DEEP_BIT];
               s_next.po.port_disable = s_reg.w_data[DIS_BIT];
            end
         end
      end
      s_next.awready = !s_next.aw_got && !s_next.bvalid;
      s_next.wready = !s_next.w_got && !s_next.bvalid;
      s_next.arready = !s_next.rvalid;

      // connection debounce; loss of cable or hard disable drops it at once
      if (!phy_in.cable_connect || hard_off) begin
         s_next.deb_cnt = '0;
         s_next.po.connected = 1'b0;
      end else if (s_reg.deb_cnt == DEB_TARGET) begin
         s_next.po.connected = 1'b1;
      end else begin
         s_next.deb_cnt = s_reg.deb_cnt + 1'b1;
      end
      s_next.po.receive_valid = phy_in.rx_signal && !hard_off;
      s_next.po.beta_mode = phy_in.beta_active && s_next.po.connected;
      s_next.po.legacy_active = s_reg.po.connected && s_reg.po.receive_valid && !s_reg.po.beta_mode;
      s_next.po.tone_enable = !hard_off;
      s_next.po.ac_maint = !hard_off;

      // connection speed frozen outside a new beta connection start
      if (phy_in.beta_conn_start && !s_reg.po.port_disable) begin
         s_next.po.conn_speed = s_reg.speed_limit;
      end

      // loop blocked: clear on bus reset or disconnect takes priority
      if (phy_in.bus_reset || (s_reg.po.connected && !s_next.po.connected)) begin
         s_next.loop_blocked = 1'b0;
      end else if (phy_in.loop_disable_enter) begin
         s_next.loop_blocked = 1'b1;
      end

      // error counter; an increment coinciding with a clearing read is dropped
      if (phy_in.remote_err_rd) s_next.po.remote_err_data = s_reg.err_cnt;
      if (err_clear) begin
         s_next.err_cnt = 8'h00;
      end else if (phy_in.invalid_cw && s_reg.err_cnt != ERR_MAX) begin
         s_next.err_cnt = s_reg.err_cnt + 8'h01;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_reg <= '0;
         s_reg.page <= PAGE_RST;
         s_reg.speed_limit <= PORT_MAX_SPEED;
         s_reg.po.conn_speed <= PORT_MAX_SPEED;
         s_reg.po.tone_enable <= 1'b1;
         s_reg.po.ac_maint <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign phy_out = s_reg.po;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   logic wr_speed;
   logic wr_link;
   logic wr_page;
   logic rd_stat_speed;
   logic rd_stat_ctrl;
   logic rd_ident_maker0;
   assign wr_speed = wr_do && !s_reg.aw_bad && s_reg.w_lane0 && s_reg.page == PAGE_STATUS
                     && s_reg.aw_idx == PS_SPEED_IDX;
   assign wr_link = wr_do && !s_reg.aw_bad && s_reg.w_lane0 && s_reg.page == PAGE_STATUS
                    && s_reg.aw_idx == PS_LINK_IDX;
   assign wr_page = wr_do && !s_reg.aw_bad && s_reg.w_lane0 && s_reg.aw_idx == PAGE_SEL_IDX;
   assign rd_stat_speed = rd_do && !ar_dec[4] && s_reg.page == PAGE_STATUS && ar_dec[3:0] == PS_SPEED_IDX;
   assign rd_stat_ctrl = rd_do && !ar_dec[4] && s_reg.page == PAGE_STATUS && ar_dec[3:0] == PS_CTRL_IDX;
   assign rd_ident_maker0 = rd_do && !ar_dec[4] && s_reg.page == PAGE_IDENT && ar_dec[3:0] == ID_MAKER0_IDX;

   speed_clamp_a: assert property (wr_speed && s_reg.w_data[2:0] > PORT_MAX_SPEED
      |=> s_reg.speed_limit == PORT_MAX_SPEED) else $error("speed not clamped");
   speed_store_a: assert property (wr_speed && s_reg.w_data[2:0] <= PORT_MAX_SPEED
      |=> s_reg.speed_limit == $past(s_reg.w_data[2:0])) else $error("speed not stored");
   conn_speed_hold_a: assert property (!phy_in.beta_conn_start |=> $stable(s_reg.po.conn_speed))
      else $error("connection speed changed");
   plug_read_a: assert property (rd_stat_speed |=> s_axi_rdata[PLUG_BIT] &&
      s_axi_rdata[SPD_CAP_LSB +: 3] == PORT_MAX_SPEED) else $error("plug or capability wrong");
   unrel_set_a: assert property (phy_in.speed_neg_fail || phy_in.sync_fail |=> s_reg.unreliable)
      else $error("unreliable not set");
   unrel_clear_a: assert property (wr_link && s_reg.w_data[UNREL_BIT] && !phy_in.speed_neg_fail
      && !phy_in.sync_fail |=> !s_reg.unreliable) else $error("unreliable not cleared");
   unrel_keep_a: assert property (wr_link && !s_reg.w_data[UNREL_BIT] && s_reg.unreliable
      |=> s_reg.unreliable) else $error("unreliable cleared by zero");
   legacy_rel_a: assert property (s_reg.po.legacy_active == $past(s_reg.po.connected &&
      s_reg.po.receive_valid && !s_reg.po.beta_mode)) else $error("legacy indication wrong");
   beta_disc_a: assert property (!s_reg.po.connected |-> !s_reg.po.beta_mode)
      else $error("beta while disconnected");
   err_sat_a: assert property (s_reg.err_cnt == ERR_MAX && !err_clear |=> s_reg.err_cnt == ERR_MAX)
      else $error("counter wrapped");
   err_inc_a: assert property (phy_in.invalid_cw && !err_clear && s_reg.err_cnt != ERR_MAX
      |=> s_reg.err_cnt == $past(s_reg.err_cnt) + 8'h01) else $error("counter missed");
   err_remote_a: assert property (phy_in.remote_err_rd |=> s_reg.err_cnt == 8'h00 &&
      s_reg.po.remote_err_data == $past(s_reg.err_cnt)) else $error("remote read wrong");
   err_clear_a: assert property (err_clear |=> s_reg.err_cnt == 8'h00)
      else $error("counter not cleared");
   loop_set_a: assert property (phy_in.loop_disable_enter && !phy_in.bus_reset && phy_in.cable_connect
      && !hard_off |=> s_reg.loop_blocked) else $error("loop flag not set");
   loop_clear_a: assert property (phy_in.bus_reset |=> !s_reg.loop_blocked)
      else $error("loop flag survived bus reset");
   loop_disc_a: assert property (s_reg.po.connected && (!phy_in.cable_connect || hard_off)
      |=> !s_reg.loop_blocked) else $error("loop flag survived disconnect");
   stby_read_a: assert property (rd_stat_ctrl |=> s_axi_rdata[STBY_BIT] == $past(phy_in.standby_state))
      else $error("standby flag wrong");
   hard_off_a: assert property (hard_off |=> !s_reg.po.connected && !s_reg.po.receive_valid
      && !s_reg.po.tone_enable && !s_reg.po.ac_maint) else $error("hard disable ignored");
   soft_dis_a: assert property (!s_reg.po.port_disable |=> s_reg.po.tone_enable)
      else $error("deep disable acted alone");
   page_sel_a: assert property (wr_page |=> s_reg.page == $past(s_reg.w_data[2:0]))
      else $error("page select not stored");
   debounce_a: assert property ($rose(s_reg.po.connected) |-> $past(s_reg.deb_cnt) == DEB_TARGET)
      else $error("connected before debounce");
   dis_start_a: assert property (phy_in.beta_conn_start && s_reg.po.port_disable
      |=> $stable(s_reg.po.conn_speed)) else $error("disabled port took a speed");
   ident_page_a: assert property (rd_ident_maker0 |=> s_axi_rdata[7:0] == MAKER_IDENT[23:16])
      else $error("ident byte wrong");

   conn_up_c: cover property ($rose(s_reg.po.connected));
   err_sat_c: cover property (s_reg.err_cnt == ERR_MAX ##1 err_clear);
   clamp_c: cover property (wr_speed && s_reg.w_data[2:0] > PORT_MAX_SPEED);
   ident_c: cover property (rd_ident_maker0);
   err_drop_c: cover property (err_clear && phy_in.invalid_cw);
endmodule : phyps_regs
